/* bench/mebi_mem.sv */
// Behavioural external memory on the multiplexed bus
`timescale 1ns/10ps
module mebi_mem (
    input  wire logic        mclk,   // system clock
    input  wire logic [7:0]  a_hi,   // upper address
    input  wire logic [15:0] ad_out, // device drive
    input  wire logic        ale,    // latch strobe
    input  wire logic        rd_n,   // read strobe
    input  wire logic        wr_n,   // write strobe
    output logic      [15:0] ad_in   // memory drive
);
    logic [15:0] mem [256];     // storage
    logic [23:0] lat_q;         // latched address
    logic [15:0] last_q = 16'h5A5A; // last driven
    // Latch address, store writes, note read data
    always @(posedge mclk) begin
        if (ale) lat_q <= {a_hi, ad_out};
        if (!wr_n) mem[lat_q[7:0]] <= ad_out;
        if (!rd_n) last_q <= ad_in;
    end
    // Released bus shows the inverse of the last value
    assign ad_in = !rd_n ? mem[lat_q[7:0]] : ~last_q;
endmodule

/* bench/mebi_top_bench.sv */
// Self-checking bench for the external bus controller
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("[ERR] %0t got %h exp %h", $time, g, e); \
    end end
module mebi_top_bench;
    import mebi_pkg::*;
    logic        mclk = 0, resetn = 0, avs_read = 0, avs_write = 0;
    logic        sys_req = 0, sys_we = 0, avs_waitrequest, sys_ack;
    logic        ad_oe, ale, rd_n, wr_n;
    logic [7:0]  avs_address = 0, a_hi;
    logic [31:0] avs_writedata = 0, sys_addr = 0, avs_readdata, rd;
    logic [15:0] sys_wdata = 0, sys_rdata, ad_in, ad_out, r_data;
    logic [3:0]  cs_n, r_cs;
    int          miscompares = 0, n_checks = 0, cyc = 0;
    int          r_n, r_ale, r_stb, r_sel, t_ack, t_ale;
    mebi_top mebi_top_i (.mclk, .resetn, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .sys_req, .sys_addr, .sys_we, .sys_wdata, .sys_rdata, .sys_ack,
        .a_hi, .ad_in, .ad_out, .ad_oe, .ale, .rd_n, .wr_n, .cs_n);
    mebi_mem mebi_mem_i (.mclk, .a_hi, .ad_out, .ale, .rd_n, .wr_n,
        .ad_in);
    always #2.5 mclk = ~mclk;
    // Cycle count and hang limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    // Verdict and end of run
    task automatic final_report;
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Whole-word register access, held until waitrequest low
    task automatic reg_acc(input logic w, input logic [7:0] a,
                           input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk); while (avs_waitrequest);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // One system access, measuring the pin activity it causes
    task automatic acc(input logic [31:0] a, input logic w,
                       input logic [15:0] d);
        @(posedge mclk);
        sys_addr <= a;
        sys_we <= w;
        sys_wdata <= d;
        sys_req <= 1'b1;
        {r_n, r_ale, r_stb, r_sel, t_ale} = '0;
        r_cs = 4'hF;
        do begin
            @(posedge mclk);
            r_n++;
            r_ale += ale;
            if (ale && t_ale == 0) t_ale = cyc;
            r_stb += !(rd_n && wr_n);
            r_sel += (cs_n != 4'hF);
            r_cs &= cs_n;
        end while (!sys_ack && r_n < 200);
        r_data = sys_rdata;
        t_ack = cyc;
        sys_req <= 1'b0;
    endtask
    function automatic logic [31:0] pick(int i, logic [31:0] m, w, t);
        pick = i == 0 ? m : i < 5 ? w : i < 9 ? t : 32'h0;
    endfunction
    // Timing word, channel enabled when en is set
    function automatic logic [31:0] mk(int c, wr, rr, al, ws, rs, wt,
                                       en);
        mk = c << 30 | wr << 27 | rr << 24 | al << 20 | ws << 18
           | rs << 16 | wt << 8 | 2 | en;
    endfunction
    // Reset values, writable bits, unmapped place
    task automatic t_regs;
        logic [7:0] ofs[10] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1C,
                                8'h40, 8'h44, 8'h48, 8'h4C, 8'h20};
        for (int i = 0; i < 10; i++) begin
            reg_acc(1'b0, ofs[i], 32'h0);
            `CHK(rd, pick(i, MEBI_MODE_RST, MEBI_WIN_RST, MEBI_TIM_RST))
            reg_acc(1'b1, ofs[i], i == 0 ? 32'hFFFF_FFFE : '1);
            reg_acc(1'b0, ofs[i], 32'h0);
            `CHK(rd, pick(i, 32'h6, MEBI_WIN_WMSK, MEBI_TIM_WMSK))
        end
    endtask
    // Window match, priority, enables and misses
    task automatic t_decode;
        logic [31:0] ca[6] = '{32'h6000_1234, 32'h6000_1234, 32'h6001_0000,
                               32'h627F_FFFE, 32'h6280_0000, 32'h6400_0000};
        logic [3:0]  ce[6] = '{4'hF, 4'hE, 4'hE, 4'h4, 4'h4, 4'h8};
        logic [3:0]  cx[6] = '{4'hE, 4'hD, 4'hF, 4'hB, 4'hF, 4'hF};
        logic [7:0]  hold;
        reg_acc(1'b1, MEBI_OFS_MODE, 32'h0);
        reg_acc(1'b1, 8'h10, 32'h6000_0000);
        reg_acc(1'b1, 8'h14, 32'h6000_0008);
        reg_acc(1'b1, 8'h18, 32'h6200_0001);
        reg_acc(1'b1, 8'h1C, 32'h6400_0000);
        for (int k = 0; k < 6; k++) begin
            for (int c = 0; c < 4; c++)
                reg_acc(1'b1, 8'h40 + 8'(4 * c), mk(0,0,0,0,0,0,0,ce[k][c]));
            acc(ca[k], 1'b0, 16'h0);
            `CHK(r_cs, cx[k])
            `CHK(r_n, cx[k] == 4'hF ? 2 : 5)
            if (cx[k] != 4'hF) hold = ca[k][23:16];
            `CHK(a_hi, hold)
            `CHK(ad_oe, 1'b0)
        end
    endtask
    // Latch, setup, wait and extension counts, data width
    task automatic t_timing;
        int ac[4] = '{1, 2, 3, 5};
        int sc[4] = '{0, 1, 2, 4};
        int wt[4] = '{0, 15, 5, 1};
        int f, ae, se, st;
        for (int i = 0; i < 4; i++) begin
            f = i == 3 ? 1 : 1 << i;
            reg_acc(1'b1, MEBI_OFS_MODE, 32'(i << 1));
            reg_acc(1'b1, MEBI_OFS_TIM0, mk(0, 0, 0, i, 3 - i, i, wt[i], 1));
            for (int w = 1; w >= 0; w--) begin
                acc(32'h6000_0010 + 32'(i), w[0], 16'h1234 + 16'(i));
                ae = ac[i] * f;
                se = sc[w ? 3 - i : i] * f;
                st = 2 + wt[i] * f;
                `CHK(r_ale, ae)
                `CHK(r_stb, st)
                `CHK(r_sel, ae + se + st)
                `CHK(r_n, 2 + ae + se + st)
            end
            `CHK(r_data, 16'h1234 + 16'(i))
        end
        reg_acc(1'b1, MEBI_OFS_TIM0, mk(0, 0, 0, 0, 0, 0, 0, 1) & ~2);
        acc(32'h6000_0013, 1'b0, 16'h0);
        `CHK(r_data, 16'h0037)
    endtask
    // Recovery gaps between back-to-back accesses
    task automatic t_recov;
        int t0;
        reg_acc(1'b1, MEBI_OFS_MODE, 32'h0);
        reg_acc(1'b1, MEBI_OFS_TIM0, mk(3, 6, 7, 1, 0, 0, 0, 1));
        acc(32'h6000_0020, 1'b0, 16'h0);
        t0 = t_ack;
        acc(32'h6000_0020, 1'b1, 16'h00A5);
        `CHK(t_ale - t0, 14)
        t0 = t_ack;
        acc(32'h6000_0020, 1'b0, 16'h0);
        `CHK(t_ale - t0, 12)
        `CHK(r_data, 16'h00A5)
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        t_regs();
        t_decode();
        t_timing();
        t_recov();
        final_report();
    end
endmodule

/* rtl/mebi_decode.sv */
// Chip select window decoder with fixed channel priority
`timescale 1ns/10ps
module mebi_decode
    import mebi_pkg::*;
#(
    parameter int NCH = mebi_pkg::MEBI_NCH
) (
    input  wire logic [31:0]          addr,     // system address
    input  wire logic [NCH-1:0][31:0] win,      // window registers
    input  wire logic [NCH-1:0]       enable,   // channel enables
    output logic      [NCH-1:0]       sel,      // one-hot winner
    output logic                      hit       // any channel won
);
    logic [NCH-1:0] match;   // raw per-channel matches
    logic           in_ext;  // address lies in external space

    // External space is 64 MB from the base
    assign in_ext = (addr[31:26] == MEBI_EXT_TOP6);

    // Per-channel compare of bits above the window size
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [7:0]  code;   // window size code
        logic [15:0] mask;   // upper bits that must match
        assign code = win[i][MEBI_WIN_SIZE +: 8];
        assign mask = ~(16'h00FF >> code[3:0]);
        // Prohibited codes never match
        assign match[i] = enable[i] && in_ext
                       && (code <= MEBI_SIZE_MAX)
                       && (((addr[31:16] ^ win[i][31:16]) & mask)
                           == 16'h0000);
    end

    // Lowest channel number wins on overlap
    always_comb begin
        sel = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (match[i]) begin
                sel    = '0;
                sel[i] = 1'b1;
            end
        end
    end

    assign hit = |match;
endmodule

/* rtl/mebi_pkg.sv */
// Package: register map, field layout, reset values and cycle code maps
package mebi_pkg;
    // Register byte offsets
    localparam logic [7:0] MEBI_OFS_MODE  = 8'h00; // bus mode control
    localparam logic [7:0] MEBI_OFS_WIN0  = 8'h10; // window 0, +4 per channel
    localparam logic [7:0] MEBI_OFS_TIM0  = 8'h40; // timing 0, +4 per channel
    localparam int         MEBI_NCH       = 4;     // chip select channels

    // Reset values
    localparam logic [31:0] MEBI_MODE_RST = 32'h0000_0000;
    localparam logic [31:0] MEBI_WIN_RST  = 32'h0000_0000;
    localparam logic [31:0] MEBI_TIM_RST  = 32'h4915_0202;

    // Writable bit masks, all other bits read as zero
    localparam logic [31:0] MEBI_MODE_WMSK = 32'h0000_0007;
    localparam logic [31:0] MEBI_WIN_WMSK  = 32'hFFFF_00FF;
    localparam logic [31:0] MEBI_TIM_WMSK  = 32'hFF3F_1F07;

    // Field positions
    localparam int MEBI_MODE_SEL   = 0;  // bus_mode_select
    localparam int MEBI_MODE_EXT   = 1;  // cycle_extension_factor lsb
    localparam int MEBI_WIN_SA     = 16; // window_start_address lsb
    localparam int MEBI_WIN_SIZE   = 0;  // window_size_code lsb
    localparam int MEBI_TIM_CSR    = 30; // select_recovery_cycles
    localparam int MEBI_TIM_WRR    = 27; // write_recovery_cycles
    localparam int MEBI_TIM_RDR    = 24; // read_recovery_cycles
    localparam int MEBI_TIM_ALE    = 20; // latch_strobe_width
    localparam int MEBI_TIM_WRS    = 18; // write_setup_cycles
    localparam int MEBI_TIM_RDS    = 16; // read_setup_cycles
    localparam int MEBI_TIM_WAIT   = 8;  // wait_cycle_count
    localparam int MEBI_TIM_WIDTH  = 1;  // data_width_select
    localparam int MEBI_TIM_EN     = 0;  // channel_enable

    // Window size codes and external space
    localparam logic [7:0]  MEBI_SIZE_MAX  = 8'h08;       // 64 Kbyte code
    localparam logic [31:0] MEBI_EXT_BASE  = 32'h6000_0000;
    localparam logic [5:0]  MEBI_EXT_TOP6  = 6'h18;       // addr[31:26]
    localparam logic [1:0]  MEBI_WID_8     = 2'h0;
    localparam logic [1:0]  MEBI_WID_16    = 2'h1;

    // Base cycle counts
    localparam logic [7:0] MEBI_STROBE_BASE = 8'h02; // strobe without waits
    localparam logic [7:0] MEBI_HOLD_CYC    = 8'h01; // end cycle after strobe

    // Latch strobe width code to clocks: 1, 2, 3, 5
    function automatic logic [7:0] mebi_ale_clk(input logic [1:0] c);
        case (c)
            2'h0:    mebi_ale_clk = 8'h01;
            2'h1:    mebi_ale_clk = 8'h02;
            2'h2:    mebi_ale_clk = 8'h03;
            default: mebi_ale_clk = 8'h05;
        endcase
    endfunction

    // Two-bit setup or select recovery code to clocks: 0, 1, 2, 4
    function automatic logic [7:0] mebi_two_clk(input logic [1:0] c);
        case (c)
            2'h0:    mebi_two_clk = 8'h00;
            2'h1:    mebi_two_clk = 8'h01;
            2'h2:    mebi_two_clk = 8'h02;
            default: mebi_two_clk = 8'h04;
        endcase
    endfunction

    // Three-bit recovery code to clocks: 0..6, then 8
    function automatic logic [7:0] mebi_rec_clk(input logic [2:0] c);
        if (c == 3'h7) begin
            mebi_rec_clk = 8'h08;
        end else begin
            mebi_rec_clk = {5'h00, c};
        end
    endfunction
endpackage

/* rtl/mebi_top.sv */
// Multiplexed external bus controller: registers and bus cycle engine
// Notes on behaviour
// - Window start bits 31:16 give upper address
// - Size code 0..8: 16 MB down to 64 KB
// - Match on bits above size; aligned start
// - Overlap: channel 0 wins, channel 3 last
// - Select recovery code: 0, 1, 2, 4 clocks
// - Read/write recovery: 0..6 or 8 clocks
// - Recovery follows every access, per channel
// - Latch strobe width: 1, 2, 3, 5 clocks
// - Default latch: strobe two clocks after address
// - Read/write setup: 0, 1, 2, 4 clocks
// - Wait field adds its value in clocks
// - Width code: 00 8-bit, 01 16-bit
// - Enable bit gates the chip select
// - Plain cycle lasts four clocks
// - Idle: address held, lines float, strobes off
// - One bus unit is one clock
// - Extension doubles or quadruples latch, setup, wait and recovery counts, not strobe base or hold
// - External space 64 MB from base
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module mebi_top
    import mebi_pkg::*;
(
    input  wire logic        mclk,            // system clock
    input  wire logic        resetn,          // async reset, low active
    // Avalon-MM register slave
    input  wire logic [7:0]  avs_address,     // byte address
    input  wire logic        avs_read,        // read request
    input  wire logic        avs_write,       // write request
    input  wire logic [31:0] avs_writedata,   // write data
    output logic      [31:0] avs_readdata,    // read data
    output logic             avs_waitrequest, // stall
    // System access port
    input  wire logic        sys_req,         // access request, level
    input  wire logic [31:0] sys_addr,        // access address
    input  wire logic        sys_we,          // 1 write, 0 read
    input  wire logic [15:0] sys_wdata,       // write data
    output logic      [15:0] sys_rdata,       // read data
    output logic             sys_ack,         // one-cycle completion
    // External pins
    output logic      [7:0]  a_hi,            // A23..A16
    input  wire logic [15:0] ad_in,           // AD15..AD0 input
    output logic      [15:0] ad_out,          // AD15..AD0 output
    output logic             ad_oe,           // AD output enable
    output logic             ale,             // address latch strobe
    output logic             rd_n,            // read strobe
    output logic             wr_n,            // write strobe
    output logic      [3:0]  cs_n             // chip selects
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ALE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RECOV
    } mebi_st_t;

    // Whole module state
    typedef struct packed {
        logic [31:0]        mode;   // mode register
        logic [3:0][31:0]   win;    // window registers
        logic [3:0][31:0]   tim;    // timing registers
        logic               rack;   // register answer
        logic [31:0]        rdat;   // register read data
        mebi_st_t           st;     // cycle phase
        logic [7:0]         cnt;    // phase counter
        logic [1:0]         ch;     // active channel
        logic               we;     // active direction
        logic [15:0]        wdat;   // latched write data
        logic [7:0]         rec;    // recovery clocks due
        logic               ack;    // access answer
        logic [15:0]        rdata;  // access read data
        logic [7:0]         a_hi;   // upper address pins
        logic [15:0]        ad_o;   // shared lines out
        logic               ad_oe;  // shared lines enable
        logic               ale;    // latch strobe
        logic               rd_n;   // read strobe
        logic               wr_n;   // write strobe
        logic [3:0]         cs_n;   // selects
    } mebi_state_t;

    mebi_state_t s_q;  // registered state
    mebi_state_t s_d;  // next state

    logic [3:0]  sel;       // decoded winner
    logic        hit;       // decoder hit
    logic [3:0]  enable;    // per-channel enables
    logic [1:0]  sel_idx;   // winner index
    logic [1:0]  ext_sh;    // extension shift
    logic [31:0] t_new;     // timing of new winner
    logic [31:0] t_act;     // timing of active channel
    logic [7:0]  ale_n;     // latch clocks
    logic [7:0]  stb_n;     // strobe clocks
    logic [7:0]  rec_n;     // recovery clocks
    logic        reg_req;   // register request pending

    // Enable bits of all channels
    for (genvar i = 0; i < 4; i++) begin : g_en
        assign enable[i] = s_q.tim[i][MEBI_TIM_EN];
    end

    mebi_decode #(
        .NCH (4)
    ) u_dec (
        .addr   (sys_addr),
        .win    (s_q.win),
        .enable (enable),
        .sel    (sel),
        .hit    (hit)
    );

    // Winner index from one-hot select
    assign sel_idx = sel[1] ? 2'h1 : sel[2] ? 2'h2 : sel[3] ? 2'h3 : 2'h0;

    // Extension shift: none, double, quadruple; prohibited acts as none
    assign ext_sh = (s_q.mode[MEBI_MODE_EXT +: 2] == 2'h1) ? 2'h1 :
                    (s_q.mode[MEBI_MODE_EXT +: 2] == 2'h2) ? 2'h2 :
                    2'h0;

    assign t_new = s_q.tim[sel_idx];
    assign t_act = s_q.tim[s_q.ch];

    // Phase lengths, in clocks of one bus unit each
    always_comb begin
        ale_n = mebi_ale_clk(t_new[MEBI_TIM_ALE +: 2]) << ext_sh;
        stb_n = MEBI_STROBE_BASE
              + ({3'h0, t_act[MEBI_TIM_WAIT +: 5]} << ext_sh);
        rec_n = (mebi_two_clk(t_new[MEBI_TIM_CSR +: 2])
              + mebi_rec_clk(sys_we ? t_new[MEBI_TIM_WRR +: 3]
                                    : t_new[MEBI_TIM_RDR +: 3]))
              << ext_sh;
    end

    assign reg_req = (avs_read || avs_write) && !s_q.rack;

    // Next-state logic: register file and cycle engine
    always_comb begin
        s_d      = s_q;
        s_d.rack = 1'b0;
        s_d.ack  = 1'b0;
        // Register slave answers one cycle after the request
        if (reg_req) begin
            s_d.rack = 1'b1;
            s_d.rdat = 32'h0000_0000;
            if (avs_address == MEBI_OFS_MODE) begin
                s_d.rdat = s_q.mode;
                if (avs_write) begin
                    // Only whole-word writes are expected
                    s_d.mode = avs_writedata & MEBI_MODE_WMSK;
                end
            end else if (avs_address[7:4] == MEBI_OFS_WIN0[7:4]
                         && avs_address[1:0] == 2'h0) begin
                s_d.rdat = s_q.win[avs_address[3:2]];
                if (avs_write) begin
                    s_d.win[avs_address[3:2]] =
                        avs_writedata & MEBI_WIN_WMSK;
                end
            end else if (avs_address[7:4] == MEBI_OFS_TIM0[7:4]
                         && avs_address[1:0] == 2'h0) begin
                s_d.rdat = s_q.tim[avs_address[3:2]];
                if (avs_write) begin
                    s_d.tim[avs_address[3:2]] =
                        avs_writedata & MEBI_TIM_WMSK;
                end
            end
        end
        // Bus cycle engine
        case (s_q.st)
            ST_IDLE: begin
                if (sys_req && !s_q.ack) begin
                    if (hit) begin
                        // Address phase: drive address, pulse latch
                        s_d.st    = ST_ALE;
                        s_d.ch    = sel_idx;
                        s_d.we    = sys_we;
                        s_d.wdat  = sys_wdata;
                        s_d.rec   = rec_n;
                        s_d.cnt   = ale_n - 8'h01;
                        s_d.a_hi  = sys_addr[23:16];
                        s_d.ad_o  = sys_addr[15:0];
                        s_d.ad_oe = 1'b1;
                        s_d.ale   = 1'b1;
                        s_d.cs_n  = ~sel;
                    end else begin
                        // Internal or unmatched: answer, pins untouched
                        s_d.ack   = 1'b1;
                        s_d.rdata = 16'h0000;
                    end
                end
            end
            ST_ALE: begin
                if (s_q.cnt != 8'h00) begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end else begin
                    s_d.ale   = 1'b0;
                    s_d.ad_o  = s_q.wdat;
                    s_d.ad_oe = s_q.we;
                    if (mebi_two_clk(s_q.we ? t_act[MEBI_TIM_WRS +: 2]
                                            : t_act[MEBI_TIM_RDS +: 2])
                        != 8'h00) begin
                        s_d.st  = ST_SETUP;
                        s_d.cnt = (mebi_two_clk(s_q.we
                                      ? t_act[MEBI_TIM_WRS +: 2]
                                      : t_act[MEBI_TIM_RDS +: 2])
                                   << ext_sh) - 8'h01;
                    end else begin
                        s_d.st   = ST_STROBE;
                        s_d.cnt  = stb_n - 8'h01;
                        s_d.rd_n = s_q.we;
                        s_d.wr_n = !s_q.we;
                    end
                end
            end
            ST_SETUP: begin
                if (s_q.cnt != 8'h00) begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end else begin
                    s_d.st   = ST_STROBE;
                    s_d.cnt  = stb_n - 8'h01;
                    s_d.rd_n = s_q.we;
                    s_d.wr_n = !s_q.we;
                end
            end
            ST_STROBE: begin
                if (s_q.cnt != 8'h00) begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end else begin
                    // Strobe ends, select released, data taken
                    s_d.st   = ST_HOLD;
                    s_d.cnt  = MEBI_HOLD_CYC - 8'h01;
                    s_d.rd_n = 1'b1;
                    s_d.wr_n = 1'b1;
                    s_d.cs_n = 4'hF;
                    s_d.ack  = 1'b1;
                    if (t_act[MEBI_TIM_WIDTH +: 2] == MEBI_WID_8) begin
                        s_d.rdata = {8'h00, ad_in[7:0]};
                    end else begin
                        s_d.rdata = ad_in;
                    end
                end
            end
            ST_HOLD: begin
                // Lines float, upper address keeps its value
                s_d.ad_oe = 1'b0;
                if (s_q.rec != 8'h00) begin
                    s_d.st  = ST_RECOV;
                    s_d.cnt = s_q.rec - 8'h01;
                end else begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_RECOV: begin
                // Dummy cycles before the next access
                if (s_q.cnt != 8'h00) begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end else begin
                    s_d.st = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_q       <= '0;
            s_q.mode  <= MEBI_MODE_RST;
            s_q.win   <= {4{MEBI_WIN_RST}};
            s_q.tim   <= {4{MEBI_TIM_RST}};
            s_q.st    <= ST_IDLE;
            s_q.rd_n  <= 1'b1;
            s_q.wr_n  <= 1'b1;
            s_q.cs_n  <= 4'hF;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign avs_waitrequest = (avs_read || avs_write) && !s_q.rack;
    assign avs_readdata    = s_q.rdat;
    assign sys_ack         = s_q.ack;
    assign sys_rdata       = s_q.rdata;
    assign a_hi            = s_q.a_hi;
    assign ad_out          = s_q.ad_o;
    assign ad_oe           = s_q.ad_oe;
    assign ale             = s_q.ale;
    assign rd_n            = s_q.rd_n;
    assign wr_n            = s_q.wr_n;
    assign cs_n            = s_q.cs_n;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence seq_addr_phase;
        $rose(ale) && (cs_n != 4'hF);
    endsequence

    sequence seq_plain_cycle;
        ale ##1 (!rd_n || !wr_n) [*2] ##1 (rd_n && wr_n && cs_n == 4'hF);
    endsequence

    AST_ONE_SELECT: assert property (
        $onehot0(~cs_n)) else $error("more than one chip select active");
    AST_ALE_SELECT: assert property (
        ale |-> (cs_n != 4'hF)) else $error("latch strobe without select");
    AST_STROBE_SELECT: assert property (
        (!rd_n || !wr_n) |-> (cs_n != 4'hF && !ale))
        else $error("strobe outside select");
    AST_NO_BOTH_STROBES: assert property (
        !(!rd_n && !wr_n)) else $error("read and write strobes together");
    AST_MISS_NO_CYCLE: assert property (
        (s_q.st == ST_IDLE && sys_req && !s_q.ack && !hit)
        |=> (sys_ack && cs_n == 4'hF && !ale && $stable(a_hi)))
        else $error("unmatched access disturbed the pins");
    AST_PLAIN_FOUR: assert property (
        (seq_addr_phase and (s_q.mode[2:1] == 2'h0)
         and (t_act[21:16] == 6'h00) and (t_act[12:8] == 5'h00))
        |-> seq_plain_cycle) else $error("plain cycle not four clocks");
    AST_DEFAULT_LATCH: assert property (
        (seq_addr_phase and (s_q.mode[2:1] == 2'h0)
         and (t_act[21:16] == 6'h10))
        |-> ##2 (!rd_n || !wr_n)) else $error("strobe not two after address");
    AST_IDLE_FLOAT: assert property (
        (s_q.st == ST_IDLE) |-> (!ad_oe && rd_n && wr_n && cs_n == 4'hF))
        else $error("pins active while idle");
    AST_REG_ANSWER: assert property (
        (avs_read && !avs_waitrequest && avs_address == 8'h20)
        |-> (avs_readdata == 32'h0000_0000))
        else $error("unmapped register not zero");
endmodule
